// File: rtl/virt_capability_and_field_encoding.sv
/*
 * Read-only capability registers and control-structure field decoder.
 * Assumes the core presents a register index and a field encoding on plain
 * synchronous ports; the answers are registered one cycle later.
 */
`default_nettype none

module virt_capability_and_field_encoding #(
    parameter logic        EXEC_ONLY       = 1'b1,
    parameter logic        WALK4           = 1'b1,
    parameter logic        MEM_UC          = 1'b1,
    parameter logic        MEM_WB          = 1'b1,
    parameter logic        PAGE_2M         = 1'b1,
    parameter logic        PAGE_1G         = 1'b1,
    parameter logic        TRANS_INV       = 1'b1,
    parameter logic        TRANS_INV_SC    = 1'b1,
    parameter logic        TRANS_INV_AC    = 1'b1,
    parameter logic        AD_FLAGS        = 1'b1,
    parameter logic        ADV_EXIT        = 1'b1,
    parameter logic        TAG_INV         = 1'b1,
    parameter logic [3:0]  TAG_INV_TYPES   = 4'hF,
    parameter logic [63:0] PRIMARY_CAP     = 64'h8000_0000_0000_0000,
    parameter logic [63:0] SECONDARY_CAP   = 64'h0000_2022_0000_0000,
    parameter logic [63:0] VM_FUNCTION_ALLOWED = 64'h0000_0000_0000_0001,
    parameter logic        HAS_POSTED_INTR = 1'b1,
    parameter logic        HAS_VIOLATION_VE = 1'b1,
    parameter logic        HAS_VIRT_INTR   = 1'b1,
    parameter logic        HAS_WRITE_LOG   = 1'b1
) (
    input  wire logic        sys_clk,          // 100 MHz clock
    input  wire logic        rst,              // Synchronous reset, high
    input  wire logic        cap_rd,           // Capability read request
    input  wire logic [11:0] cap_index,        // Capability register index
    output logic [63:0]      cap_data,         // Read data
    output logic             cap_valid,        // Read answered (index exists)
    output logic             cap_error,        // Read of absent register
    input  wire logic        dec_req,          // Encoding decode request
    input  wire logic [31:0] field_encoding,   // Field selector
    output logic             dec_done,         // Decode result present
    output logic             field_valid,      // Encoding names a present field
    output logic [4:0]       field_id,         // Selected field
    output logic [1:0]       field_width,      // Width code
    output logic [1:0]       field_type,       // Type code
    output logic [8:0]       field_index,      // Index code
    output logic             field_high,       // High-half access
    input  wire logic [63:0] vm_function_ctl,  // Function controls of entry
    input  wire logic        secondary_active, // Secondary controls active
    input  wire logic        vm_function_en,   // Function enabling active
    output logic             entry_fail,       // Function control check fails
    input  wire logic        mode_exec_ctl,    // Mode-based execute active
    input  wire logic [10:0] entry_perm,       // Translation entry low bits
    output logic             exec_only_ok,     // Entry allowed as execute-only
    input  wire logic        violation_event,  // Translation violation exit
    output logic             adv_exit_info     // Advanced exit information given
);

    // =========================================================================
    // Constant register images
    localparam logic [63:0] CAP_IMAGE =
        (64'(EXEC_ONLY)    << virt_cap_pkg::EXEC_ONLY_BIT) |
        (64'(WALK4)        << virt_cap_pkg::WALK4_BIT) |
        (64'(MEM_UC)       << virt_cap_pkg::MEM_UC_BIT) |
        (64'(MEM_WB)       << virt_cap_pkg::MEM_WB_BIT) |
        (64'(PAGE_2M)      << virt_cap_pkg::PAGE_2M_BIT) |
        (64'(PAGE_1G)      << virt_cap_pkg::PAGE_1G_BIT) |
        (64'(TRANS_INV)    << virt_cap_pkg::TRANS_INV_BIT) |
        (64'(TRANS_INV_SC) << virt_cap_pkg::TRANS_INV_SC_BIT) |
        (64'(TRANS_INV_AC) << virt_cap_pkg::TRANS_INV_AC_BIT) |
        (64'(AD_FLAGS)     << virt_cap_pkg::AD_FLAGS_BIT) |
        (64'(ADV_EXIT)     << virt_cap_pkg::ADV_EXIT_BIT) |
        (64'(TAG_INV)      << virt_cap_pkg::TAG_INV_BIT) |
        (64'(TAG_INV_TYPES) << virt_cap_pkg::TAG_INV_ADDR_BIT);
    // Mask keeps reserved positions at zero whatever the parameters say
    localparam logic [63:0] CAP_VALUE = CAP_IMAGE & virt_cap_pkg::CAP_DEFINED_MASK;

    localparam logic SECONDARY_OK = PRIMARY_CAP[virt_cap_pkg::PRIM_SECONDARY_ACT_BIT];
    localparam logic CAP_EXISTS = SECONDARY_OK &&
        (SECONDARY_CAP[virt_cap_pkg::SEC_NESTED_BIT] || SECONDARY_CAP[virt_cap_pkg::SEC_TAG_BIT]);
    localparam logic FUNC_EXISTS = SECONDARY_OK && SECONDARY_CAP[virt_cap_pkg::SEC_VMFUNC_BIT];
    localparam logic HAS_TAG = SECONDARY_CAP[virt_cap_pkg::SEC_TAG_BIT];

    // Refuse type bits without their instruction at elaboration, not at run time
    if (TAG_INV_TYPES != 4'h0 && !TAG_INV) begin : g_bad_tag_types
        $error("tag invalidate types need tag invalidate support");
    end
    if ((TRANS_INV_SC || TRANS_INV_AC) && !TRANS_INV) begin : g_bad_trans_types
        $error("translation invalidate types need the instruction");
    end

    // =========================================================================
    // State
    typedef struct packed {
        logic [63:0] cap_data;
        logic        cap_valid;
        logic        cap_error;
        logic        dec_done;
        logic        field_valid;
        logic [4:0]  field_id;
        logic [1:0]  field_width;
        logic [1:0]  field_type;
        logic [8:0]  field_index;
        logic        field_high;
        logic        entry_fail;
        logic        exec_only_ok;
        logic        adv_exit_info;
    } state_s;

    state_s state;
    state_s next_state;

    // Maps a 16-bit field's type and index to its identifier
    function automatic logic [4:0] field16(input logic [1:0] ftype, input logic [8:0] idx);
        logic [4:0] id;
        id = virt_cap_pkg::FLD_NONE;
        unique case (ftype)
            virt_cap_pkg::TYPE_CONTROL: begin
                if (idx == 9'h000 && HAS_TAG) begin
                    id = virt_cap_pkg::FLD_PROCESSOR_TAG;
                end else if (idx == 9'h001 && HAS_POSTED_INTR) begin
                    id = virt_cap_pkg::FLD_NOTIFY_VECTOR;
                end else if (idx == virt_cap_pkg::CTRL16_LAST_INDEX && HAS_VIOLATION_VE) begin
                    id = virt_cap_pkg::FLD_TRANSLATION_PTR_INDEX;
                end
            end
            virt_cap_pkg::TYPE_GUEST: begin
                if (idx <= 9'h007) begin
                    id = 5'(virt_cap_pkg::FLD_GUEST_ES + idx[2:0]);
                end else if (idx == 9'h008 && HAS_VIRT_INTR) begin
                    id = virt_cap_pkg::FLD_GUEST_INTR_STATUS;
                end else if (idx == virt_cap_pkg::GUEST16_LAST_INDEX && HAS_WRITE_LOG) begin
                    id = virt_cap_pkg::FLD_GUEST_WRITE_LOG_INDEX;
                end
            end
            virt_cap_pkg::TYPE_HOST: begin
                if (idx <= virt_cap_pkg::HOST16_LAST_INDEX) begin
                    id = 5'(virt_cap_pkg::FLD_HOST_ES + idx[2:0]);
                end
            end
            default: id = virt_cap_pkg::FLD_NONE;
        endcase
        return id;
    endfunction : field16

    // =========================================================================
    // Next state
    always_comb begin
        logic [1:0] w;
        logic [1:0] t;
        logic [8:0] ix;
        logic       rsvd_ok;
        logic [4:0] id;
        w = field_encoding[virt_cap_pkg::ENC_WIDTH_HI:virt_cap_pkg::ENC_WIDTH_LO];
        t = field_encoding[virt_cap_pkg::ENC_TYPE_HI:virt_cap_pkg::ENC_TYPE_LO];
        ix = field_encoding[virt_cap_pkg::ENC_INDEX_HI:virt_cap_pkg::ENC_INDEX_LO];
        rsvd_ok = (field_encoding[31:virt_cap_pkg::ENC_RSVD_HI_LO] == 17'h00000)
                  && !field_encoding[virt_cap_pkg::ENC_RSVD12_BIT];
        id = field16(t, ix);
        next_state = state;
        next_state.cap_valid = 1'b0;
        next_state.cap_error = 1'b0;
        next_state.dec_done = 1'b0;
        if (cap_rd) begin
            next_state.cap_data = 64'h0000_0000_0000_0000;
            if (cap_index == virt_cap_pkg::NESTED_TRANSLATION_TAG_CAPABILITY_IDX && CAP_EXISTS) begin
                next_state.cap_data = CAP_VALUE;
                next_state.cap_valid = 1'b1;
            end else if (cap_index == virt_cap_pkg::VM_FUNCTION_CAPABILITY_IDX && FUNC_EXISTS) begin
                next_state.cap_data = VM_FUNCTION_ALLOWED;
                next_state.cap_valid = 1'b1;
            end else begin
                next_state.cap_error = 1'b1;
            end
        end
        if (dec_req) begin
            next_state.dec_done = 1'b1;
            next_state.field_width = w;
            next_state.field_type = t;
            next_state.field_index = ix;
            next_state.field_high = field_encoding[virt_cap_pkg::ENC_ACCESS_BIT];
            next_state.field_id = virt_cap_pkg::FLD_NONE;
            next_state.field_valid = 1'b0;
            if (rsvd_ok && w == virt_cap_pkg::WIDTH_16
                && !field_encoding[virt_cap_pkg::ENC_ACCESS_BIT]) begin
                next_state.field_id = id;
                next_state.field_valid = (id != virt_cap_pkg::FLD_NONE);
            end else if (rsvd_ok && w == virt_cap_pkg::WIDTH_64) begin
                // Wide tables are decoded elsewhere; only FLD_WIDE64 and the raw width, type, index and half are given here
                next_state.field_id = virt_cap_pkg::FLD_WIDE64;
                next_state.field_valid = 1'b1;
            end
        end
        next_state.entry_fail = secondary_active && vm_function_en
                                && ((vm_function_ctl & ~VM_FUNCTION_ALLOWED) != 64'h0);
        next_state.exec_only_ok = CAP_VALUE[virt_cap_pkg::EXEC_ONLY_BIT] && entry_perm[1:0] == 2'h0
                                  && (entry_perm[2] || (mode_exec_ctl && entry_perm[10]));
        next_state.adv_exit_info = violation_event && CAP_VALUE[virt_cap_pkg::ADV_EXIT_BIT];
        if (rst) begin
            next_state = '0;
        end
    end

    always_ff @(posedge sys_clk) begin
        state <= next_state;
    end

    assign cap_data      = state.cap_data;
    assign cap_valid     = state.cap_valid;
    assign cap_error     = state.cap_error;
    assign dec_done      = state.dec_done;
    assign field_valid   = state.field_valid;
    assign field_id      = state.field_id;
    assign field_width   = state.field_width;
    assign field_type    = state.field_type;
    assign field_index   = state.field_index;
    assign field_high    = state.field_high;
    assign entry_fail    = state.entry_fail;
    assign exec_only_ok  = state.exec_only_ok;
    assign adv_exit_info = state.adv_exit_info;

endmodule : virt_capability_and_field_encoding

`default_nettype wire

// File: rtl/virt_cap_pkg.sv
/*
 * Constants for the virtualization capability block: register indexes,
 * capability bit positions and control-structure field encodings.
 * Assumes a single-clock core that reads capability registers by index.
 */
`default_nettype none

package virt_cap_pkg;

    // =========================================================================
    // Register indexes
    localparam logic [11:0] NESTED_TRANSLATION_TAG_CAPABILITY_IDX = 12'h48C;
    localparam logic [11:0] VM_FUNCTION_CAPABILITY_IDX            = 12'h491;

    // =========================================================================
    // Capability bit positions
    localparam int EXEC_ONLY_BIT      = 0;
    localparam int WALK4_BIT          = 6;
    localparam int MEM_UC_BIT         = 8;
    localparam int MEM_WB_BIT         = 14;
    localparam int PAGE_2M_BIT        = 16;
    localparam int PAGE_1G_BIT        = 17;
    localparam int TRANS_INV_BIT      = 20;
    localparam int AD_FLAGS_BIT       = 21;
    localparam int ADV_EXIT_BIT       = 22;
    localparam int TRANS_INV_SC_BIT   = 25;
    localparam int TRANS_INV_AC_BIT   = 26;
    localparam int TAG_INV_BIT        = 32;
    localparam int TAG_INV_ADDR_BIT   = 40;
    localparam int TAG_INV_SC_BIT     = 41;
    localparam int TAG_INV_AC_BIT     = 42;
    localparam int TAG_INV_SCG_BIT    = 43;
    localparam logic [63:0] CAP_DEFINED_MASK = 64'h0000_0F01_0673_4141;

    // Positions in the primary and secondary control capabilities
    localparam int PRIM_SECONDARY_ACT_BIT  = 63;
    localparam int SEC_NESTED_BIT          = 33;
    localparam int SEC_TAG_BIT             = 37;
    localparam int SEC_VMFUNC_BIT          = 45;

    // =========================================================================
    // Field encoding layout
    localparam int ENC_ACCESS_BIT = 0;
    localparam int ENC_INDEX_LO   = 1;
    localparam int ENC_INDEX_HI   = 9;
    localparam int ENC_TYPE_LO    = 10;
    localparam int ENC_TYPE_HI    = 11;
    localparam int ENC_RSVD12_BIT = 12;
    localparam int ENC_WIDTH_LO   = 13;
    localparam int ENC_WIDTH_HI   = 14;
    localparam int ENC_RSVD_HI_LO = 15;

    localparam logic [1:0] WIDTH_16 = 2'h0;
    localparam logic [1:0] WIDTH_64 = 2'h1;
    localparam logic [1:0] TYPE_CONTROL = 2'h0;
    localparam logic [1:0] TYPE_GUEST   = 2'h2;
    localparam logic [1:0] TYPE_HOST    = 2'h3;

    // Field identifiers reported by the decoder: the 16-bit fields, FLD_NONE and FLD_WIDE64
    typedef enum logic [4:0] {
        FLD_NONE             = 5'h00,
        FLD_PROCESSOR_TAG    = 5'h01,
        FLD_NOTIFY_VECTOR    = 5'h02,
        FLD_TRANSLATION_PTR_INDEX = 5'h03,
        FLD_GUEST_ES         = 5'h04,
        FLD_GUEST_CS         = 5'h05,
        FLD_GUEST_SS         = 5'h06,
        FLD_GUEST_DS         = 5'h07,
        FLD_GUEST_FS         = 5'h08,
        FLD_GUEST_GS         = 5'h09,
        FLD_GUEST_LOCAL_TABLE = 5'h0A,
        FLD_GUEST_TASK       = 5'h0B,
        FLD_GUEST_INTR_STATUS = 5'h0C,
        FLD_GUEST_WRITE_LOG_INDEX = 5'h0D,
        FLD_HOST_ES          = 5'h0E,
        FLD_HOST_CS          = 5'h0F,
        FLD_HOST_SS          = 5'h10,
        FLD_HOST_DS          = 5'h11,
        FLD_HOST_FS          = 5'h12,
        FLD_HOST_GS          = 5'h13,
        FLD_HOST_TASK        = 5'h14,
        FLD_WIDE64           = 5'h15
    } field_id_e;

    localparam logic [8:0] CTRL16_LAST_INDEX  = 9'h002;
    localparam logic [8:0] GUEST16_LAST_INDEX = 9'h009;
    localparam logic [8:0] HOST16_LAST_INDEX  = 9'h006;

endpackage : virt_cap_pkg

`default_nettype wire

// File: tb/virt_capability_and_field_encoding_assertions.sv
/* Concurrent checks on the capability and field decoder ports.
   Assumes the default parameter set of the block (image 0F0106734141). */
`default_nettype none

module virt_capability_and_field_encoding_checker (
    input wire logic        sys_clk,          // clock
    input wire logic        rst,              // reset
    input wire logic        cap_rd,           // read
    input wire logic [11:0] cap_index,        // index
    input wire logic [63:0] cap_data,         // data
    input wire logic        cap_valid,        // hit
    input wire logic        cap_error,        // miss
    input wire logic        dec_req,          // decode
    input wire logic [31:0] field_encoding,   // selector
    input wire logic        dec_done,         // done
    input wire logic        field_valid,      // present
    input wire logic [4:0]  field_id,         // field
    input wire logic [1:0]  field_type,       // type
    input wire logic [8:0]  field_index,      // index
    input wire logic [63:0] vm_function_ctl,  // controls
    input wire logic        secondary_active, // active
    input wire logic        vm_function_en,   // enable
    input wire logic        entry_fail,       // fail
    input wire logic [10:0] entry_perm,       // entry
    input wire logic        exec_only_ok,     // ok
    input wire logic        violation_event,  // event
    input wire logic        adv_exit_info     // info
);
    localparam logic [63:0] CAP_IMAGE = 64'h0000_0F01_0673_4141;
    logic [31:0] enc_q;

    // ==========================================================================
    // Helper
    always_ff @(posedge sys_clk) begin
        enc_q <= field_encoding;
    end

    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);

    // ==========================================================================
    // Properties
    a_cap_image: assert property (cap_rd && cap_index == 12'h48C |=>
        cap_valid && cap_data == CAP_IMAGE) else $error("capability image wrong");
    a_reserved_zero: assert property (cap_valid |->
        (cap_data & ~virt_cap_pkg::CAP_DEFINED_MASK) == 64'h0) else $error("reserved bit set");
    a_absent_read: assert property (cap_rd && cap_index != 12'h48C && cap_index != 12'h491 |=>
        cap_error && !cap_valid && cap_data == 64'h0) else $error("absent index answered");
    a_cap_quiet: assert property (!cap_rd |=> !cap_valid && !cap_error && $stable(cap_data))
        else $error("capability changed without read");
    a_dec_pulse: assert property (dec_req |=> dec_done ##1 (dec_done == $past(dec_req)))
        else $error("decode not answered in one cycle");
    a_rsvd_refused: assert property (dec_req && (field_encoding[31:15] != 17'h0 || field_encoding[12])
        |=> !field_valid && field_id == 5'h00) else $error("reserved encoding accepted");
    a_field_raw: assert property (dec_req |=> field_type == enc_q[11:10] && field_index == enc_q[9:1])
        else $error("type or index wrong");
    a_entry_fail: assert property (entry_fail == $past(secondary_active && vm_function_en
        && vm_function_ctl[63:1] != 63'h0)) else $error("function control check wrong");
    a_exec_refused: assert property (entry_perm[1:0] != 2'h0 |=> !exec_only_ok)
        else $error("data access entry taken as execute only");
    a_adv_exit: assert property (adv_exit_info == $past(violation_event))
        else $error("advanced exit info wrong");
endmodule : virt_capability_and_field_encoding_checker

bind virt_capability_and_field_encoding virt_capability_and_field_encoding_checker u_checker (
    .sys_clk(sys_clk), .rst(rst), .cap_rd(cap_rd), .cap_index(cap_index), .cap_data(cap_data),
    .cap_valid(cap_valid), .cap_error(cap_error), .dec_req(dec_req), .field_encoding(field_encoding),
    .dec_done(dec_done), .field_valid(field_valid), .field_id(field_id), .field_type(field_type),
    .field_index(field_index), .vm_function_ctl(vm_function_ctl), .secondary_active(secondary_active),
    .vm_function_en(vm_function_en), .entry_fail(entry_fail), .entry_perm(entry_perm),
    .exec_only_ok(exec_only_ok), .violation_event(violation_event), .adv_exit_info(adv_exit_info));

`default_nettype wire

// File: tb/test_virt_capability_and_field_encoding.sv
/* Self-checking bench: reads, decodes and entry checks against a model.
   Assumes the block's default parameters and one-cycle registered answers. */
`default_nettype none
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin n_mismatch++; \
    $display("ERROR %s expected %h seen %h", nm, e, g); end end

module test_virt_capability_and_field_encoding;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 1'b0, rst = 1'b1, cap_rd = 1'b0, dec_req = 1'b0, secondary_active = 1'b0;
    logic vm_function_en = 1'b0, mode_exec_ctl = 1'b0, violation_event = 1'b0;
    logic [11:0] cap_index = 12'h0;
    logic [31:0] field_encoding = 32'h0, p_enc, r, r2;
    logic [63:0] vm_function_ctl = 64'h0, cap_data, img, held;
    logic [10:0] entry_perm = 11'h0;
    logic cap_valid, cap_error, dec_done, field_valid, field_high, entry_fail, exec_only_ok, adv_exit_info;
    logic p_rd, p_dec, x_fail, x_exec, x_adv;
    logic [4:0] field_id;
    logic [1:0] field_width, field_type;
    logic [8:0] field_index;
    logic [64:0] x_cap;
    logic [5:0] x_dec;
    int n_mismatch = 0, checks_done = 0;
    int bits[16] = '{0, 6, 8, 14, 16, 17, 20, 21, 22, 25, 26, 32, 40, 41, 42, 43};
    logic [31:0] odd_list[8] = '{32'h803, 32'h400, 32'h8000_0802, 32'h1802, 32'h4000, 32'h6000, 32'h2000, 32'h2001};

    always #5 sys_clk = ~sys_clk;

    virt_capability_and_field_encoding u_virt_capability_and_field_encoding (
        .sys_clk(sys_clk), .rst(rst), .cap_rd(cap_rd), .cap_index(cap_index), .cap_data(cap_data),
        .cap_valid(cap_valid), .cap_error(cap_error), .dec_req(dec_req), .field_encoding(field_encoding),
        .dec_done(dec_done), .field_valid(field_valid), .field_id(field_id), .field_width(field_width),
        .field_type(field_type), .field_index(field_index), .field_high(field_high),
        .vm_function_ctl(vm_function_ctl), .secondary_active(secondary_active), .vm_function_en(vm_function_en),
        .entry_fail(entry_fail), .mode_exec_ctl(mode_exec_ctl), .entry_perm(entry_perm),
        .exec_only_ok(exec_only_ok), .violation_event(violation_event), .adv_exit_info(adv_exit_info));

    // ==========================================================================
    // Model
    function automatic logic [5:0] dec_exp(input logic [31:0] e);
        int idx;
        idx = int'(e[9:1]);
        if (e[31:15] != 17'h0 || e[12]) return 6'h00;
        if (e[14:13] == 2'h1) return {1'b1, 5'h15};
        if (e[14:13] != 2'h0 || e[0]) return 6'h00;
        if (e[11:10] == 2'h0 && idx <= 2) return {1'b1, 5'(1 + idx)};
        if (e[11:10] == 2'h2 && idx <= 9) return {1'b1, 5'(4 + idx)};
        if (e[11:10] == 2'h3 && idx <= 6) return {1'b1, 5'(14 + idx)};
        return 6'h00;
    endfunction : dec_exp

    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : end_of_test

    // Checks the answer to the previous cycle, then presents the next request
    task automatic drive(input logic rd, input logic [11:0] idx, input logic dr, input logic [31:0] enc);
        @(negedge sys_clk);
        `CHK("cap_valid", p_rd & x_cap[64], cap_valid);
        `CHK("cap_error", p_rd & ~x_cap[64], cap_error);
        `CHK("cap_data", held, cap_data);
        `CHK("dec_done", p_dec, dec_done);
        if (p_dec) begin
            `CHK("field_valid", x_dec[5], field_valid);
            `CHK("field_id", x_dec[4:0], field_id);
            `CHK("field_raw", {p_enc[14:13], p_enc[11:0]}, {field_width, field_type, field_index, field_high});
        end
        `CHK("entry_fail", x_fail, entry_fail);
        `CHK("exec_only_ok", x_exec, exec_only_ok);
        `CHK("adv_exit_info", x_adv, adv_exit_info);
        r = $urandom;
        {cap_rd, cap_index, dec_req, field_encoding} = {rd, idx, dr, enc};
        vm_function_ctl = r[0] ? {32'($urandom), 32'($urandom)} : {63'h0, r[1]};
        {secondary_active, vm_function_en, mode_exec_ctl, violation_event} = r[5:2];
        entry_perm = r[20:10] & 11'h407;
        x_cap = idx == 12'h48C ? {1'b1, img} : (idx == 12'h491 ? {1'b1, 64'h1} : 65'h0);
        if (rd) held = x_cap[63:0];
        {p_rd, p_dec, p_enc, x_dec} = {rd, dr, enc, dec_exp(enc)};
        x_fail = secondary_active & vm_function_en & (vm_function_ctl[63:1] != 63'h0);
        x_exec = img[0] & (entry_perm[1:0] == 2'h0) & (entry_perm[2] | (mode_exec_ctl & entry_perm[10]));
        x_adv = violation_event & img[22];
    endtask : drive

    task automatic do_reset(input int n);
        @(negedge sys_clk);
        {rst, cap_rd, dec_req, secondary_active, vm_function_en, violation_event} = 6'h20;
        {p_rd, p_dec, x_fail, x_exec, x_adv, held} = '0;
        entry_perm = 11'h0;
        repeat (n) @(negedge sys_clk);
        rst = 1'b0;
    endtask : do_reset

    // ==========================================================================
    // Sequence
    initial begin
        img = '0;
        foreach (bits[k]) img[bits[k]] = 1'b1;
        r = $urandom(52);
        do_reset(16);
        foreach (odd_list[k]) drive(1'b1, 12'h48A + 12'(k), 1'b1, odd_list[k]);
        for (int t = 0; t < 36; t++) begin
            drive(1'b1, 12'h491, 1'b1, {20'h0, 2'(t / 12) + 2'(t >= 12), 10'(2 * (t % 12))});
        end
        drive(1'b0, 12'h0, 1'b0, 32'h0);
        do_reset(2);
        repeat (3000) begin
            r2 = $urandom;
            drive(r2[0], r2[1] ? 12'h48C : 12'(r2[31:20]), r2[2], (r2 & 32'h7C1F) | {15'h0, r2[3], 16'h0});
        end
        drive(1'b0, 12'h0, 1'b0, 32'h0);
        end_of_test;
    end

    initial begin
        #100000;
        n_mismatch++;
        end_of_test;
    end
endmodule : test_virt_capability_and_field_encoding

`default_nettype wire
